// *** hdl/mac_table_pkg.sv ***
// Shared constants, register indices and carrier types for the address learning table
package mac_table_pkg;
  // Table geometry: 512 hash sets of four ways, 2048 entries in all
  localparam int WAYS = 4;
  localparam int SET_BITS = 9;
  localparam int SETS = 512;
  localparam int ENTRIES = SETS * WAYS;
  localparam int INDEX_BITS = 11;
  // Entry field positions within the 70-bit word
  localparam int ENTRY_W = 70;
  localparam int POS_BAD = 69;
  localparam int POS_STATIC = 68;
  localparam int POS_OCCUPIED = 67;
  localparam int POS_CTRL_HI = 66;
  localparam int POS_CTRL_LO = 58;
  localparam int POS_PMAP_HI = 57;
  localparam int POS_PMAP_LO = 52;
  localparam int POS_FID_HI = 51;
  localparam int POS_FID_LO = 48;
  localparam int POS_MAC_HI = 47;
  // Static control field bits
  localparam int CB_INTRUSION = 8;
  localparam int CB_SPAN = 7;
  localparam int CB_MGMT = 6;
  localparam int CB_CROSS = 5;
  localparam int CB_TAG_HI = 4;
  localparam int CB_TAG_LO = 3;
  localparam int CB_LPE = 2;
  localparam int CB_LP_HI = 1;
  localparam logic [1:0] TAG_ALWAYS_UNTAGGED = 2'h3;
  // Age value given to a freshly learned or refreshed entry
  localparam logic [8:0] AGE_INIT_DEFAULT = 9'h1ff;
  // Register indices; byte address is four times the index
  localparam logic [7:0] REG_PRI_IGMP = 8'h0c;
  localparam logic [7:0] REG_PRI_ARP = 8'h0d;
  localparam logic [7:0] REG_PRI_CTRL = 8'h3d;
  localparam logic [7:0] REG_CMD_MAC_LO = 8'h40;
  localparam logic [7:0] REG_CMD_MAC_HI = 8'h41;
  localparam logic [7:0] REG_CMD_FIELDS = 8'h42;
  localparam logic [7:0] REG_CMD_GO = 8'h43;
  localparam logic [7:0] REG_STATUS = 8'h44;
  localparam logic [7:0] REG_STAT_FIELDS = 8'h45;
  localparam logic [7:0] REG_STAT_MAC_LO = 8'h46;
  localparam logic [7:0] REG_STAT_MAC_HI = 8'h47;
  localparam logic [7:0] REG_AGE = 8'h48;
  // Priority register fields
  localparam int PRI_EN_BIT = 2;
  localparam logic [2:0] PRI_RESET = 3'h0;
  // CPU commands and access codes
  localparam logic [2:0] CMD_WRITE = 3'h0;
  localparam logic [2:0] CMD_ERASE = 3'h1;
  localparam logic [2:0] CMD_SEARCH = 3'h2;
  localparam logic [3:0] ACC_CREATE = 4'h7;
  localparam logic [3:0] ACC_FULL = 4'hf;
  localparam logic [3:0] ACC_ADDR_FID = 4'he;
  // Command results
  localparam logic [2:0] RES_OK = 3'h0;
  localparam logic [2:0] RES_FULL = 3'h1;
  localparam logic [2:0] RES_MISS = 3'h2;
  localparam logic [2:0] RES_BAD_CMD = 3'h3;

  typedef enum logic [2:0] {STP_DISABLED, STP_BLOCKING, STP_LISTENING, STP_LEARNING, STP_FORWARDING} stp_t;
  typedef enum logic [1:0] {CLS_OTHER, CLS_CTRL, CLS_ARP, CLS_IGMP} frame_class_t;

  typedef struct packed {
    logic bad;
    logic is_static;
    logic occupied;
    logic [8:0] ctrl;
    logic [5:0] portmap;
    logic [3:0] forwarding_group_id;
    logic [47:0] mac;
  } entry_t;

  typedef struct packed {
    logic [47:0] sa;
    logic [47:0] da;
    logic [3:0] forwarding_group_id;
    logic [2:0] port;
    frame_class_t cls;
    stp_t stp;
    logic security_violation;
    logic vlan_violation;
    logic pause;
    logic limit_reached;
    logic learn_disabled;
    logic illegal;
    logic stag_present;
    logic learn_permit_bit;
    logic learn_permit_valid;
    logic tag_priority_valid;
    logic [1:0] tag_pri;
    logic port_priority_enable;
    logic [1:0] port_pri;
    logic vlan_pri_enable;
    logic [1:0] vlan_pri;
    logic ip_pri_enable;
    logic [1:0] ip_pri;
    logic tcp_pri_enable;
    logic [1:0] tcp_pri;
  } frame_t;

  typedef struct packed {
    logic [1:0] queue;
    logic da_hit;
    logic [5:0] portmap;
    logic [1:0] egress_tag_option;
    logic span;
    logic mgmt;
    logic cross_domain_flag;
    logic sa_intrusion;
    logic learned;
  } result_t;
endpackage

// *** hdl/mac_address_learning_table.sv ***
// Four-way hashed address learning table with queue selection and APB access
//
// Functional notes
// - Four-way hashed sets share one key
// - Capacity of 2048 entries on chip
// - Hit needs both address and group
// - Learn new source when absent
// - Relearn when stored port differs
// - Violations, pause, limit, illegal suppress learning
// - Special tag can forbid learning
// - No learning in disabled/blocking/listening
// - Skip learning when set all static
// - CPU creates, erases, marks static
// - Static entries never age out
// - Entry is 70 bits, fixed layout
// - Fail flag marks self-test failures
// - Static entries hold control bits
// - Dynamic entries hold age timer
// - Intrusion, span, management, cross flags honoured
// - Bits 4:3 pick egress tagging
// - Learned priority enable and value
// - Port map and group per entry
// - Valid tag priority wins always
// - Control classes: learned then fixed
// - ARP uses own priority when enabled
// - IGMP/MLD uses own priority when enabled
// - System priority fixed precedence chain
`timescale 1ns/1ns
module mac_address_learning_table
#(
  parameter logic [8:0] AGE_INIT = mac_table_pkg::AGE_INIT_DEFAULT
)
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic FRAME_VALID,
  input wire mac_table_pkg::frame_t FRAME_IN,
  input wire logic BIST_FAIL_VALID,
  input wire logic [mac_table_pkg::INDEX_BITS-1:0] BIST_FAIL_INDEX,
  output logic RESULT_VALID,
  output mac_table_pkg::result_t RESULT_OUT
);
  import mac_table_pkg::*;

  // flip-flop store, set index then way
  entry_t table_q [SETS][WAYS];
  logic [2:0] pri_igmp; // Enable and queue for IGMP/MLD
  logic [2:0] pri_arp; // Enable and queue for ARP/RARP
  logic [1:0] pri_ctrl; // Queue for control classes
  entry_t cmd_entry; // Staged CPU entry
  logic [6:0] cmd_code; // Command and access control
  logic cmd_pending; // Busy flag
  logic [2:0] cmd_result;
  entry_t stat_entry; // Lookup answer of the last command of any kind
  logic age_active; // Sweep in progress
  logic [SET_BITS-1:0] age_ptr;
  logic [7:0] reg_index;

  // Fold address and group into a set index
  function automatic logic [SET_BITS-1:0] hash_key(input logic [47:0] mac, input logic [3:0] forwarding_group_id);
    logic [SET_BITS-1:0] h;
    h = SET_BITS'(forwarding_group_id);
    for (int i = 0; i < 48; i++)
      h[i % SET_BITS] ^= mac[i];
    return h;
  endfunction

  // Returns {hit, way}
  function automatic logic [2:0] find_way(input logic [SET_BITS-1:0] s, input logic [47:0] mac,
                                          input logic [3:0] forwarding_group_id);
    logic [2:0] r;
    r = 3'h0;
    // address and group must both match
    for (int w = WAYS - 1; w >= 0; w--)
      if (table_q[s][w].occupied && table_q[s][w].mac == mac && table_q[s][w].forwarding_group_id == forwarding_group_id)
        r = {1'b1, 2'(w)};
    return r;
  endfunction

  // Returns {found, way}: free way first, then a dynamic one to replace
  function automatic logic [2:0] pick_way(input logic [SET_BITS-1:0] s);
    logic [2:0] r;
    r = 3'h0;
    for (int w = WAYS - 1; w >= 0; w--)
      if (!table_q[s][w].bad && table_q[s][w].occupied && !table_q[s][w].is_static)
        r = {1'b1, 2'(w)};
    for (int w = WAYS - 1; w >= 0; w--)
      if (!table_q[s][w].bad && !table_q[s][w].occupied)
        r = {1'b1, 2'(w)};
    return r;
  endfunction

  function automatic logic all_static(input logic [SET_BITS-1:0] s);
    logic r;
    r = 1'b1;
    for (int w = 0; w < WAYS; w++)
      r &= table_q[s][w].occupied & table_q[s][w].is_static;
    return r;
  endfunction

  // One age tick for one entry
  function automatic entry_t age_step(input entry_t e);
    entry_t n;
    n = e;
    if (e.occupied && !e.is_static)
    begin
      if (e.ctrl == 9'h000)
        n.occupied = 1'b0;
      else
        n.ctrl = e.ctrl - 9'h001;
    end
    return n;
  endfunction

  // Frame-side lookups
  logic [SET_BITS-1:0] sa_set, da_set, cmd_set;
  logic [2:0] sa_find, da_find, sa_pick, cmd_find, cmd_pick;
  entry_t sa_entry, da_entry, learn_entry, cmd_write;
  logic [5:0] rx_pmap;
  logic learn_ok, set_full_static, learn_do, refresh_do, da_lpe, cmd_go, cmd_wr_do;
  logic [1:0] learn_way, sys_pri, next_queue, cmd_way;
  logic [2:0] next_result;
  logic [6:0] cmd_erase_way;

  always_comb
  begin
    sa_set = hash_key(FRAME_IN.sa, FRAME_IN.forwarding_group_id);
    da_set = hash_key(FRAME_IN.da, FRAME_IN.forwarding_group_id);
    sa_find = find_way(sa_set, FRAME_IN.sa, FRAME_IN.forwarding_group_id);
    da_find = find_way(da_set, FRAME_IN.da, FRAME_IN.forwarding_group_id);
    sa_pick = pick_way(sa_set);
    sa_entry = table_q[sa_set][sa_find[1:0]];
    da_entry = table_q[da_set][da_find[1:0]];
    rx_pmap = 6'h01 << FRAME_IN.port;
    set_full_static = all_static(sa_set);
    learn_ok = !(FRAME_IN.security_violation || FRAME_IN.vlan_violation || FRAME_IN.pause
                 || FRAME_IN.limit_reached || FRAME_IN.learn_disabled || FRAME_IN.illegal)
               && !(FRAME_IN.stag_present && !FRAME_IN.learn_permit_bit && FRAME_IN.learn_permit_valid)
               && (FRAME_IN.stp == STP_LEARNING || FRAME_IN.stp == STP_FORWARDING);
    // miss, or hit on dynamic entry with another port
    refresh_do = 1'b0;
    learn_do = 1'b0;
    learn_way = sa_pick[1:0];
    if (sa_find[2])
    begin
      learn_way = sa_find[1:0];
      refresh_do = FRAME_VALID && learn_ok && !sa_entry.is_static && sa_entry.portmap == rx_pmap;
      learn_do = FRAME_VALID && learn_ok && !sa_entry.is_static && sa_entry.portmap != rx_pmap;
    end
    else
    begin
      // skip when no way can take it
      learn_do = FRAME_VALID && learn_ok && sa_pick[2] && !set_full_static;
    end
    learn_entry = '{bad: 1'b0, is_static: 1'b0, occupied: 1'b1, ctrl: AGE_INIT, portmap: rx_pmap,
                    forwarding_group_id: FRAME_IN.forwarding_group_id, mac: FRAME_IN.sa};
    // learned priority only in static entries
    da_lpe = da_find[2] && da_entry.is_static && da_entry.ctrl[CB_LPE];
    if (da_lpe)
      sys_pri = da_entry.ctrl[CB_LP_HI:0];
    else if (FRAME_IN.port_priority_enable)
      sys_pri = FRAME_IN.port_pri;
    else if (FRAME_IN.vlan_pri_enable)
      sys_pri = FRAME_IN.vlan_pri;
    else if (FRAME_IN.ip_pri_enable)
      sys_pri = FRAME_IN.ip_pri;
    else if (FRAME_IN.tcp_pri_enable)
      sys_pri = FRAME_IN.tcp_pri;
    else
      sys_pri = 2'h0;
    // Per-class queue choice
    unique case (FRAME_IN.cls)
      CLS_CTRL: next_queue = da_lpe ? da_entry.ctrl[CB_LP_HI:0] : pri_ctrl;
      CLS_ARP: next_queue = pri_arp[PRI_EN_BIT] ? pri_arp[1:0] : sys_pri;
      CLS_IGMP: next_queue = pri_igmp[PRI_EN_BIT] ? pri_igmp[1:0] : sys_pri;
      CLS_OTHER: next_queue = sys_pri;
    endcase
    if (FRAME_IN.tag_priority_valid)
      next_queue = FRAME_IN.tag_pri;
  end

  // CPU command decode; runs only in a cycle with no frame
  always_comb
  begin
    cmd_go = cmd_pending && !FRAME_VALID;
    cmd_set = hash_key(cmd_entry.mac, cmd_entry.forwarding_group_id);
    cmd_find = find_way(cmd_set, cmd_entry.mac, cmd_entry.forwarding_group_id);
    cmd_pick = pick_way(cmd_set);
    cmd_way = cmd_find[2] ? cmd_find[1:0] : cmd_pick[1:0];
    cmd_write = cmd_entry;
    cmd_write.bad = table_q[cmd_set][cmd_way].bad;
    cmd_write.occupied = 1'b1;
    cmd_wr_do = 1'b0;
    cmd_erase_way = 7'h00;
    next_result = RES_BAD_CMD;
    if (cmd_code == {CMD_WRITE, ACC_CREATE} || cmd_code == {CMD_WRITE, ACC_FULL})
    begin
      cmd_wr_do = cmd_go && (cmd_find[2] || (cmd_pick[2] && !all_static(cmd_set)));
      next_result = (cmd_find[2] || (cmd_pick[2] && !all_static(cmd_set))) ? RES_OK : RES_FULL;
    end
    else if (cmd_code == {CMD_ERASE, ACC_FULL})
    begin
      cmd_erase_way = {cmd_go && cmd_find[2], 4'h0, cmd_find[1:0]};
      next_result = cmd_find[2] ? RES_OK : RES_MISS;
    end
    else if (cmd_code == {CMD_SEARCH, ACC_ADDR_FID})
      next_result = cmd_find[2] ? RES_OK : RES_MISS;
  end

  // Table writes: frame learning, CPU command, age sweep, self-test marks
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      for (int s = 0; s < SETS; s++)
        for (int w = 0; w < WAYS; w++)
          table_q[s][w] <= '0;
    end
    else
    begin
      if (learn_do)
        table_q[sa_set][learn_way] <= learn_entry;
      else if (refresh_do)
        table_q[sa_set][learn_way].ctrl <= AGE_INIT;
      if (cmd_wr_do)
        table_q[cmd_set][cmd_way] <= cmd_write;
      if (cmd_erase_way[6])
        table_q[cmd_set][cmd_erase_way[1:0]].occupied <= 1'b0;
      if (age_active && !FRAME_VALID && !cmd_pending)
        for (int w = 0; w < WAYS; w++)
          table_q[age_ptr][w] <= age_step(table_q[age_ptr][w]);
      if (BIST_FAIL_VALID)
        table_q[BIST_FAIL_INDEX[INDEX_BITS-1:2]][BIST_FAIL_INDEX[1:0]].bad <= 1'b1;
    end
  end

  // Per-frame answer, one cycle after the frame
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      RESULT_VALID <= 1'b0;
      RESULT_OUT <= '0;
    end
    else
    begin
      RESULT_VALID <= FRAME_VALID;
      RESULT_OUT.queue <= next_queue;
      RESULT_OUT.da_hit <= da_find[2];
      // port map of the destination entry
      RESULT_OUT.portmap <= da_find[2] ? da_entry.portmap : 6'h00;
      // static flags apply to static entries only
      RESULT_OUT.egress_tag_option <= (da_find[2] && da_entry.is_static) ? da_entry.ctrl[CB_TAG_HI:CB_TAG_LO] : 2'h0;
      RESULT_OUT.span <= da_find[2] && da_entry.is_static && da_entry.ctrl[CB_SPAN];
      RESULT_OUT.mgmt <= da_find[2] && da_entry.is_static && da_entry.ctrl[CB_MGMT];
      RESULT_OUT.cross_domain_flag <= da_find[2] && da_entry.is_static && da_entry.ctrl[CB_CROSS];
      RESULT_OUT.sa_intrusion <= sa_find[2] && sa_entry.is_static && sa_entry.ctrl[CB_INTRUSION];
      RESULT_OUT.learned <= learn_do;
    end
  end

  // Command staging, busy flag and status
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      cmd_entry <= '0;
      cmd_code <= 7'h00;
      cmd_pending <= 1'b0;
      cmd_result <= RES_OK;
      stat_entry <= '0;
    end
    else
    begin
      if (cmd_go)
      begin
        cmd_pending <= 1'b0;
        cmd_result <= next_result;
        stat_entry <= cmd_find[2] ? table_q[cmd_set][cmd_find[1:0]] : '0;
      end
      // Staging registers are frozen while busy
      if (PSEL && PENABLE && PREADY && PWRITE && !cmd_pending)
      begin
        unique case (reg_index)
          REG_CMD_MAC_LO: cmd_entry.mac[31:0] <= PWDATA;
          REG_CMD_MAC_HI: cmd_entry.mac[47:32] <= PWDATA[15:0];
          REG_CMD_FIELDS: cmd_entry[POS_STATIC:POS_FID_LO] <= {PWDATA[25], 1'b0, PWDATA[24:16], PWDATA[9:0]};
          REG_CMD_GO:
          begin
            cmd_code <= PWDATA[6:0];
            cmd_pending <= 1'b1;
          end
          default: ;
        endcase
      end
    end
  end

  // Priority configuration and age sweep control
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      pri_igmp <= PRI_RESET;
      pri_arp <= PRI_RESET;
      pri_ctrl <= 2'h0;
      age_active <= 1'b0;
      age_ptr <= '0;
    end
    else
    begin
      if (age_active && !FRAME_VALID && !cmd_pending)
      begin
        age_ptr <= age_ptr + 9'h001;
        age_active <= age_ptr != 9'h1ff;
      end
      if (PSEL && PENABLE && PREADY && PWRITE)
      begin
        unique case (reg_index)
          REG_PRI_IGMP: pri_igmp <= PWDATA[2:0];
          REG_PRI_ARP: pri_arp <= PWDATA[2:0];
          REG_PRI_CTRL: pri_ctrl <= PWDATA[1:0];
          REG_AGE: if (PWDATA[0] && !age_active) age_active <= 1'b1;
          default: ;
        endcase
      end
    end
  end

  // APB slave: answer in the first access cycle, data prepared in setup
  assign reg_index = PADDR[9:2];
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0000_0000;
    end
    else
    begin
      PREADY <= PSEL && !PENABLE;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0000_0000;
      if (PSEL && !PENABLE)
      begin
        unique case (reg_index)
          REG_PRI_IGMP: PRDATA <= {29'h0000_0000, pri_igmp};
          REG_PRI_ARP: PRDATA <= {29'h0000_0000, pri_arp};
          REG_PRI_CTRL: PRDATA <= {30'h0000_0000, pri_ctrl};
          REG_CMD_MAC_LO: PRDATA <= cmd_entry.mac[31:0];
          REG_CMD_MAC_HI: PRDATA <= {16'h0000, cmd_entry.mac[47:32]};
          REG_CMD_FIELDS: PRDATA <= {6'h00, cmd_entry.is_static, cmd_entry.ctrl, 6'h00, cmd_entry.portmap, cmd_entry.forwarding_group_id};
          REG_CMD_GO: PRDATA <= {25'h000_0000, cmd_code};
          REG_STATUS: PRDATA <= {16'h0000, cmd_pending, cmd_result, 9'h000, stat_entry.bad,
                                 stat_entry.occupied, stat_entry.is_static};
          REG_STAT_FIELDS: PRDATA <= {7'h00, stat_entry.ctrl, 6'h00, stat_entry.portmap, stat_entry.forwarding_group_id};
          REG_STAT_MAC_LO: PRDATA <= stat_entry.mac[31:0];
          REG_STAT_MAC_HI: PRDATA <= {16'h0000, stat_entry.mac[47:32]};
          REG_AGE: PRDATA <= {31'h0000_0000, age_active};
          default: PSLVERR <= 1'b1;
        endcase
        if (PADDR[11:10] != 2'h0 || PADDR[1:0] != 2'h0)
          PSLVERR <= 1'b1;
      end
    end
  end

  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  sequence frame_taken_s;
    FRAME_VALID;
  endsequence
  sequence answer_s;
    RESULT_VALID;
  endsequence

  frame_answer_a: assert property (frame_taken_s |=> answer_s) else $error("frame without answer");
  tag_priority_wins_a: assert property (FRAME_VALID && FRAME_IN.tag_priority_valid
    |=> RESULT_OUT.queue == $past(FRAME_IN.tag_pri)) else $error("tag priority ignored");
  stp_no_learn_a: assert property (FRAME_VALID && FRAME_IN.stp inside {STP_DISABLED, STP_BLOCKING, STP_LISTENING}
    |=> !RESULT_OUT.learned) else $error("learned in blocked port state");
  stag_no_learn_a: assert property (FRAME_VALID && FRAME_IN.stag_present && !FRAME_IN.learn_permit_bit
    && FRAME_IN.learn_permit_valid |=> !RESULT_OUT.learned) else $error("learned against special tag");
  suppress_learn_a: assert property (FRAME_VALID && (FRAME_IN.pause || FRAME_IN.illegal || FRAME_IN.limit_reached)
    |=> !RESULT_OUT.learned) else $error("learned from suppressed frame");
  full_static_a: assert property (FRAME_VALID && set_full_static && !sa_find[2]
    |=> !RESULT_OUT.learned) else $error("learned into all-static set");
  learn_new_a: assert property (FRAME_VALID && learn_ok && !sa_find[2] && sa_pick[2] && !set_full_static
    |=> RESULT_OUT.learned) else $error("absent source not learned");
  static_kept_a: assert property (age_active && !FRAME_VALID && !cmd_pending && !BIST_FAIL_VALID
    && table_q[age_ptr][0].is_static |=> table_q[$past(age_ptr)][0] == $past(table_q[age_ptr][0]))
    else $error("static entry aged");
  ctrl_class_a: assert property (FRAME_VALID && !FRAME_IN.tag_priority_valid && FRAME_IN.cls == CLS_CTRL && !da_lpe
    |=> RESULT_OUT.queue == $past(pri_ctrl)) else $error("control class queue wrong");
  cmd_done_a: assert property (cmd_pending && !FRAME_VALID |=> !cmd_pending && cmd_result == $past(next_result))
    else $error("command not completed");
endmodule

// *** sim/frame_port.sv ***
// Receive path model that presents frame descriptors to the table
`timescale 1ns/1ns
module frame_port
  import mac_table_pkg::*;
(
  input wire logic clk,
  input wire logic go,
  input wire mac_table_pkg::frame_t d,
  output logic valid = 1'b0,
  output mac_table_pkg::frame_t fr = '0
);
  // One frame per request; idle bus flips to its inverse every cycle so stale data never looks valid
  always @(posedge clk)
  begin
    valid <= go;
    fr <= go ? d : ~fr;
  end
endmodule

// *** sim/test_mac_address_learning_table.sv ***
// Self-checking bench for the address learning table
`timescale 1ns/1ns
module test_mac_address_learning_table;
  import mac_table_pkg::*;
  typedef struct packed {frame_t f; logic l; logic [1:0] q;} row_t;
  localparam logic [47:0] MS = 48'h0000_0a0b_0c0d;
  localparam logic [47:0] SA = 48'h0000_0000_1111;
  localparam logic [47:0] SB = 48'h0000_0000_2222;
  localparam logic [47:0] MI = 48'h0000_0000_3333;
  logic bist_v = 1'b0;
  logic [10:0] bist_i = 11'h000;
  logic clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd, fl;
  logic pready, pslverr, err, fv, rv, gv;
  frame_t d = '0, fr, f;
  result_t res, got;
  row_t rows[11];
  int errors = 0, checks_done = 0, cyc = 0, i, n;
  mac_address_learning_table #(.AGE_INIT(9'h002)) uut (.CLK(clk), .RESET(reset), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .FRAME_VALID(fv), .FRAME_IN(fr), .BIST_FAIL_VALID(bist_v),
    .BIST_FAIL_INDEX(bist_i), .RESULT_VALID(rv), .RESULT_OUT(res));
  frame_port fp (.clk(clk), .go(go), .d(d), .valid(fv), .fr(fr));
  initial
    forever #50 clk = ~clk;
  // Cut a hang short
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      report_and_stop;
    end
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // APB transfer; ready, read data and error taken at the rising edge that ends the access
  task automatic apb(input logic w, input logic [7:0] x, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, x, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // Wait states end when ready rises; only the bench timeout bounds them
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // Stage a table command, fire it and poll busy; status left in rd
  task automatic cpu(input logic [47:0] m, input logic [31:0] fw, input logic [6:0] op);
    apb(1'b1, REG_CMD_MAC_LO, m[31:0]);
    apb(1'b1, REG_CMD_MAC_HI, {16'h0000, m[47:32]});
    apb(1'b1, REG_CMD_FIELDS, fw);
    apb(1'b1, REG_CMD_GO, {25'h000_0000, op});
    for (int k = 0; k < 8 && (k == 0 || rd[15] !== 1'b0); k++)
      apb(1'b0, REG_STATUS, 32'h0000_0000);
  endtask
  // Present one frame and catch the one-cycle result
  task automatic send(input frame_t fi);
    go <= 1'b1;
    d <= fi;
    @(posedge clk);
    go <= 1'b0;
    gv = 1'b0;
    for (int k = 0; k < 4 && gv !== 1'b1; k++)
    begin
      @(negedge clk);
      gv = rv;
      got = res;
    end
    @(posedge clk);
  endtask
  function automatic frame_t mk(input logic [47:0] s, input logic [3:0] g, input logic [2:0] p,
    input frame_class_t c);
    frame_t t;
    t = '0;
    t.sa = s;
    t.da = MS;
    t.forwarding_group_id = g;
    t.port = p;
    t.cls = c;
    t.stp = STP_FORWARDING;
    t.port_priority_enable = 1'b1;
    t.port_pri = 2'h1;
    return t;
  endfunction
  initial
  begin
    repeat (10) @(posedge clk);
    chk("ready in reset", 32'h0000_0000, 32'(pready));
    reset <= 1'b0;
    @(posedge clk);
    apb(1'b0, REG_PRI_ARP, 32'h0000_0000);
    chk("arp pri reset", 32'h0000_0000, rd);
    apb(1'b0, 8'h30, 32'h0000_0000);
    chk("unmapped error", 32'h0000_0001, 32'(err));
    // Learning table: learn, refresh, relearn, group split, suppressions
    for (i = 0; i < 11; i++)
      rows[i] = '{mk(i < 4 ? SA : SB, i == 3 ? 4'h2 : 4'h1, i < 2 ? 3'h2 : 3'h3, CLS_OTHER), 1'b0, 2'h1};
    rows[0].l = 1'b1;
    rows[2].l = 1'b1;
    rows[3].l = 1'b1;
    rows[4].f.pause = 1'b1;
    rows[5].f.illegal = 1'b1;
    rows[6].f.stag_present = 1'b1;
    rows[6].f.learn_permit_valid = 1'b1;
    rows[6].f.tag_priority_valid = 1'b1;
    rows[6].f.tag_pri = 2'h3;
    rows[6].q = 2'h3;
    rows[7].f.stp = STP_DISABLED;
    rows[8].f.stp = STP_BLOCKING;
    rows[9].f.stp = STP_LISTENING;
    rows[10].f.port_priority_enable = 1'b0;
    rows[10].f.vlan_pri_enable = 1'b1;
    rows[10].f.vlan_pri = 2'h2;
    rows[10].f.ip_pri_enable = 1'b1;
    rows[10].f.ip_pri = 2'h3;
    rows[10].q = 2'h2;
    rows[10].l = 1'b1;
    for (i = 0; i < 11; i++)
    begin
      send(rows[i].f);
      chk("row result", 32'({1'b1, rows[i].l, rows[i].q}), 32'({gv, got.learned, got.queue}));
    end
    $display("row tests done");
    fl = {6'h00, 1'b1, 9'h09f, 6'h00, 6'h21, 4'h5};
    cpu(MS, fl, {CMD_WRITE, ACC_CREATE});
    chk("create status", 32'({1'b0, RES_OK}), 32'(rd[15:12]));
    cpu(MS, fl, {CMD_SEARCH, ACC_ADDR_FID});
    chk("search status", 32'({1'b0, RES_OK, 3'h3}), 32'({rd[15:12], rd[2:0]}));
    apb(1'b0, REG_STAT_FIELDS, 32'h0000_0000);
    chk("search fields", {7'h00, 9'h09f, 6'h00, 6'h21, 4'h5}, rd);
    f = mk(SB, 4'h5, 3'h4, CLS_CTRL);
    send(f);
    chk("static hit", 32'({2'h3, 1'b1, 6'h21, 2'h3, 3'h4}), 32'({got.queue, got.da_hit, got.portmap,
      got.egress_tag_option, got.span, got.mgmt, got.cross_domain_flag}));
    f.tag_priority_valid = 1'b1;
    send(f);
    chk("tag pri wins", 32'h0000_0000, 32'(got.queue));
    apb(1'b1, REG_PRI_CTRL, 32'h0000_0002);
    send(mk(SB, 4'h6, 3'h4, CLS_CTRL));
    chk("ctrl fallback", 32'h0000_0002, 32'({got.da_hit, got.queue}));
    cpu(MI, {6'h00, 1'b1, 9'h160, 6'h00, 6'h02, 4'h7}, {CMD_WRITE, ACC_FULL});
    f = mk(MI, 4'h7, 3'h1, CLS_OTHER);
    f.da = MI;
    send(f);
    chk("static flags", 32'({5'b10110, 6'h02, 2'h1}), 32'({got.sa_intrusion, got.span, got.mgmt,
      got.cross_domain_flag, got.learned, got.portmap, got.queue}));
    $display("static tests done");
    for (i = 0; i < 2; i++)
    begin
      apb(1'b1, i ? REG_PRI_IGMP : REG_PRI_ARP, 32'h0000_0007);
      f = mk(SA, 4'h1, 3'h3, i ? CLS_IGMP : CLS_ARP);
      send(f);
      chk("class pri on", 32'h0000_0003, 32'(got.queue));
      apb(1'b1, i ? REG_PRI_IGMP : REG_PRI_ARP, 32'h0000_0003);
      send(f);
      chk("class pri off", 32'h0000_0001, 32'(got.queue));
    end
    $display("class tests done");
    // Several sweeps so a dynamic entry runs out of age
    repeat (4)
    begin
      apb(1'b1, REG_AGE, 32'h0000_0001);
      apb(1'b0, REG_AGE, 32'h0000_0000);
      for (n = 0; n < 400 && rd[0] !== 1'b0; n++)
        apb(1'b0, REG_AGE, 32'h0000_0000);
    end
    cpu(SA, 32'h0000_0001, {CMD_SEARCH, ACC_ADDR_FID});
    chk("aged dynamic", 32'({1'b0, RES_MISS}), 32'(rd[15:12]));
    cpu(MS, fl, {CMD_SEARCH, ACC_ADDR_FID});
    chk("static kept", 32'({1'b0, RES_OK}), 32'(rd[15:12]));
    cpu(MS, fl, {CMD_SEARCH, 4'h0});
    chk("bad command", 32'({1'b0, RES_BAD_CMD}), 32'(rd[15:12]));
    $display("ageing tests done");
    // Self-test marks every location, then the static entry must show it
    for (i = 0; i < ENTRIES; i++)
    begin
      bist_v <= 1'b1;
      bist_i <= 11'(i);
      @(posedge clk);
    end
    bist_v <= 1'b0;
    cpu(MS, fl, {CMD_SEARCH, ACC_ADDR_FID});
    chk("bist mark", 32'({1'b0, RES_OK, 3'h7}), 32'({rd[15:12], rd[2:0]}));
    cpu(MS, fl, {CMD_ERASE, ACC_FULL});
    chk("erase status", 32'({1'b0, RES_OK}), 32'(rd[15:12]));
    cpu(MS, fl, {CMD_SEARCH, ACC_ADDR_FID});
    chk("erased miss", 32'({1'b0, RES_MISS}), 32'(rd[15:12]));
    $display("erase tests done");
    report_and_stop;
  end
endmodule
